// ===== hw/ascl_pkg.sv
/*
  Constants for the active serial configuration master.
  Assumes a 10 MHz system clock; the link clock is derived from it.
*/
package ascl_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned LINK_PERIOD_NS = 800;
  localparam int unsigned SYS_PERIOD_NS = 1000000000 / CLK_HZ;
  // Half period of the link clock in system cycles, rounded down, at least one
  localparam int unsigned HALF_CYC_RAW = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int unsigned HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
  localparam logic [7:0] READ_OPCODE = 8'h03;
  localparam int unsigned OPCODE_BITS = 8;
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned HDR_BITS = OPCODE_BITS + ADDR_BITS;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned INIT_CYC = 8;
  localparam logic [1:0] SCHEME_ACTIVE = 2'h0;
  localparam logic [1:0] SCHEME_PASSIVE = 2'h1;
  typedef enum logic [2:0] {
    ASCL_IDLE, ASCL_HDR, ASCL_DATA, ASCL_CHECK, ASCL_ERR, ASCL_INIT, ASCL_USER
  } ascl_state_e;
endpackage

// ===== hw/ascl_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock domain, synchronous reset and clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module ascl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  // Pointer wrap logic only serves power-of-two depths
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end

  // Flags and pointer advance
  always_comb begin
    in_ready_o = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    out_valid_o = (wp_r != rp_r);
    out_data_o = mem_r[rp_r[AW-1:0]];
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wp_nxt = wp_r + (AW+1)'(push);
    rp_nxt = rp_r + (AW+1)'(pop);
  end

  // Pointer and storage registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      if (push) begin
        mem_r[wp_r[AW-1:0]] <= in_data_i;
      end
    end
  end
endmodule // ascl_fifo
`default_nettype wire

// ===== hw/ascl_master.sv
/*
  Active serial configuration master: selects the flash, shifts a read
  instruction and address, captures bytes into a FIFO, and runs the
  completion and error handshake.
  Assumes config_data_in and done/error pins arrive asynchronously.
*/
// Overview of operation
// - Master makes the configuration clock from its own clock while the flash is selected (header and data).
// - Clock, select, instruction and data pins map one-to-one to flash pins.
// - Select driven low before any transfer begins.
// - Instruction then address shifted out on the instruction line.
// - Master captures each data bit on the falling configuration clock edge.
// - Master drives done low during configuration; it drives the error pin only in an error pulse.
// - Done late or early makes the master pulse error low to restart.
// - On success master releases done so the pull-up lifts it.
// - Initialization starts after done is high; user mode follows.
// - First chain member is strapped active serial and is master.
// - Later chain members are strapped passive serial slaves.
`timescale 1ns/1ps
`default_nettype none
module ascl_master
  import ascl_pkg::*;
#(
  parameter int unsigned IMAGE_BYTES = 64,
  parameter logic [ascl_pkg::ADDR_BITS-1:0] START_ADDR = 24'h000000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [1:0] scheme_select_i,
  output logic config_clock_o,
  output logic master_select_out_o,
  output logic serial_instr_out_o,
  input wire logic config_data_in_i,
  input wire logic conf_done_i,
  output logic conf_done_o,
  output logic conf_done_oe_o,
  input wire logic status_low_i,
  output logic status_low_o,
  output logic status_low_oe_o,
  output logic [ascl_pkg::BYTE_BITS-1:0] byte_data_o,
  output logic byte_valid_o,
  input wire logic byte_ready_i,
  output logic user_mode_o,
  output logic error_o
);
  import ascl_pkg::*;

  // An empty image would never leave the data phase
  if (IMAGE_BYTES < 1) begin : g_bad_image
    $error("IMAGE_BYTES must be at least one");
  end

  ascl_state_e st_r, st_nxt;
  logic [1:0] data_sync_r, done_sync_r, stat_sync_r;
  logic [7:0] div_r, div_nxt;
  logic clk_r, clk_nxt, sel_r, sel_nxt, sdo_r, sdo_nxt;
  logic [HDR_BITS-1:0] hdr_r, hdr_nxt;
  logic [5:0] bit_r, bit_nxt;
  logic [BYTE_BITS-1:0] sh_r, sh_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic done_oe_r, done_oe_nxt, stat_oe_r, stat_oe_nxt, user_r, user_nxt, err_r, err_nxt;
  logic [BYTE_BITS-1:0] push_data;
  logic push_valid, fifo_ready, fifo_valid, fall;
  logic [BYTE_BITS-1:0] fifo_data;
  logic out_valid_r, out_valid_nxt;
  logic [BYTE_BITS-1:0] out_data_r, out_data_nxt;

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_sync_r <= 2'h0;
      done_sync_r <= 2'h0;
      stat_sync_r <= 2'h3;
    end else if (ce_i) begin
      data_sync_r <= {data_sync_r[0], config_data_in_i};
      done_sync_r <= {done_sync_r[0], conf_done_i};
      stat_sync_r <= {stat_sync_r[0], status_low_i};
    end
  end

  // Falling-edge event of the derived configuration clock
  assign fall = (div_r == 8'(HALF_CYC - 1)) && clk_r;

  // Main sequencer next-state logic
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    clk_nxt = clk_r;
    sel_nxt = sel_r;
    sdo_nxt = sdo_r;
    hdr_nxt = hdr_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    done_oe_nxt = done_oe_r;
    stat_oe_nxt = stat_oe_r;
    user_nxt = user_r;
    err_nxt = err_r;
    push_valid = 1'b0;
    push_data = sh_r;
    // Clock divider runs only while the flash is selected
    if (st_r == ASCL_HDR || st_r == ASCL_DATA) begin
      if (div_r == 8'(HALF_CYC - 1)) begin
        div_nxt = 8'h00;
        // Hold the clock low while the FIFO cannot take another byte
        if (!(clk_r == 1'b0 && st_r == ASCL_DATA && !fifo_ready)) begin
          clk_nxt = !clk_r;
        end
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end
    unique case (st_r)
      ASCL_IDLE: begin
        clk_nxt = 1'b0;
        div_nxt = 8'h00;
        // Only the active serial strap makes this end a master
        if (start_i && scheme_select_i == SCHEME_ACTIVE) begin
          sel_nxt = 1'b0;
          hdr_nxt = {READ_OPCODE, START_ADDR};
          sdo_nxt = READ_OPCODE[OPCODE_BITS-1];
          bit_nxt = 6'h00;
          done_oe_nxt = 1'b1;
          stat_oe_nxt = 1'b0;
          err_nxt = 1'b0;
          user_nxt = 1'b0;
          cnt_nxt = '0;
        end
      end
      ASCL_HDR: begin
        // Flash samples on rise, so change the instruction bit on fall
        if (fall) begin
          if (bit_r == 6'(HDR_BITS - 1)) begin
            bit_nxt = 6'h00;
            st_nxt = ASCL_DATA;
          end else begin
            hdr_nxt = {hdr_r[HDR_BITS-2:0], 1'b0};
            sdo_nxt = hdr_r[HDR_BITS-2];
            bit_nxt = bit_r + 6'h01;
          end
        end
      end
      ASCL_DATA: begin
        // Data changes and is captured on the falling edge
        if (fall) begin
          sh_nxt = {sh_r[BYTE_BITS-2:0], data_sync_r[1]};
          push_data = {sh_r[BYTE_BITS-2:0], data_sync_r[1]};
          if (bit_r == 6'(BYTE_BITS - 1)) begin
            bit_nxt = 6'h00;
            push_valid = 1'b1;
            cnt_nxt = cnt_r + 32'h1;
            if (cnt_r == 32'(IMAGE_BYTES - 1)) begin
              st_nxt = ASCL_CHECK;
              sel_nxt = 1'b1;
              clk_nxt = 1'b0;
              done_oe_nxt = 1'b0;
              cnt_nxt = '0;
            end
          end else begin
            bit_nxt = bit_r + 6'h01;
          end
          // Done rising before the last byte is an error
          if (done_sync_r[1] && cnt_r != 32'(IMAGE_BYTES - 1)) begin
            st_nxt = ASCL_ERR;
            sel_nxt = 1'b1;
            clk_nxt = 1'b0;
            cnt_nxt = '0;
          end
        end
      end
      ASCL_CHECK: begin
        cnt_nxt = cnt_r + 32'h1;
        if (done_sync_r[1]) begin
          st_nxt = ASCL_INIT;
          cnt_nxt = '0;
        end else if (cnt_r == 32'(INIT_CYC - 1)) begin
          st_nxt = ASCL_ERR;
          cnt_nxt = '0;
        end
      end
      ASCL_ERR: begin
        // Low pulse on the error pin restarts configuration
        stat_oe_nxt = 1'b1;
        err_nxt = 1'b1;
        done_oe_nxt = 1'b1;
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r == 32'(INIT_CYC - 1)) begin
          stat_oe_nxt = 1'b0;
          st_nxt = ASCL_IDLE;
        end
      end
      ASCL_INIT: begin
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r == 32'(INIT_CYC - 1)) begin
          st_nxt = ASCL_USER;
          user_nxt = 1'b1;
        end
      end
      ASCL_USER: begin
        user_nxt = 1'b1;
      end
      default: st_nxt = ASCL_IDLE;
    endcase
    if (st_r == ASCL_IDLE && start_i && scheme_select_i == SCHEME_ACTIVE) begin
      st_nxt = ASCL_HDR;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r <= ASCL_IDLE;
      div_r <= 8'h00;
      clk_r <= 1'b0;
      sel_r <= 1'b1;
      sdo_r <= 1'b0;
      hdr_r <= '0;
      bit_r <= 6'h00;
      sh_r <= '0;
      cnt_r <= '0;
      done_oe_r <= 1'b0;
      stat_oe_r <= 1'b0;
      user_r <= 1'b0;
      err_r <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      clk_r <= clk_nxt;
      sel_r <= sel_nxt;
      sdo_r <= sdo_nxt;
      hdr_r <= hdr_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      done_oe_r <= done_oe_nxt;
      stat_oe_r <= stat_oe_nxt;
      user_r <= user_nxt;
      err_r <= err_nxt;
    end
  end

  // Captured bytes wait here until the user side takes them
  ascl_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_data_i(push_data),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(!out_valid_r || byte_ready_i)
  );

  // Output stage register so the byte port comes from flip-flops
  always_comb begin
    out_valid_nxt = out_valid_r;
    out_data_nxt = out_data_r;
    if (!out_valid_r || byte_ready_i) begin
      out_valid_nxt = fifo_valid;
      out_data_nxt = fifo_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (ce_i) begin
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
    end
  end

  // Pin drive: done and error pins are driven low while enabled
  assign config_clock_o = clk_r;
  assign master_select_out_o = sel_r;
  assign serial_instr_out_o = sdo_r;
  assign conf_done_o = 1'b0;
  assign conf_done_oe_o = done_oe_r;
  assign status_low_o = 1'b0;
  assign status_low_oe_o = stat_oe_r;
  assign byte_data_o = out_data_r;
  assign byte_valid_o = out_valid_r;
  assign user_mode_o = user_r;
  assign error_o = err_r;

  // Protocol checks on the sequencer and its pins
  a_select_before_clk: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(clk_r) |-> !sel_r) else $error("clock toggled while deselected");
  a_err_pulse_len: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(stat_oe_r) && ce_i |-> stat_oe_r [*2]) else $error("error pulse too short");
  a_user_after_done: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(user_r) |-> done_sync_r[1] && !done_oe_r) else $error("user mode without done");
  a_done_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_r == ASCL_CHECK |-> !done_oe_r) else $error("done held low on success");
  a_data_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_r == ASCL_DATA || st_r == ASCL_HDR |-> done_oe_r) else $error("done not driven");
  a_desel_clock_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sel_r |-> !clk_r) else $error("clock high while deselected");
  // The error pin must read back low two enabled cycles into the pulse
  a_err_pin_seen: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(stat_oe_r) && ce_i ##1 ce_i |-> ##1 !stat_sync_r[1]) else $error("error pin not seen low");
  c_user: cover property (@(posedge clk_sys_i) $rose(user_r));
  c_error: cover property (@(posedge clk_sys_i) $rose(err_r));
  c_stall: cover property (@(posedge clk_sys_i) st_r == ASCL_DATA && !fifo_ready);
endmodule // ascl_master
`default_nettype wire

// ===== testbench/ascl_flash_model.sv
/*
  Behavioural serial flash standing at the far side of the master.
  Assumes one master drives clock, select and instruction line.
*/
`timescale 1ns/1ps
`default_nettype none
module ascl_flash_model (
  input wire logic config_clock_i,
  input wire logic flash_select_low_i,
  input wire logic serial_instr_in_i,
  input wire logic slow_i,
  output logic flash_data_o,
  output logic [31:0] header_o
);
  int rise_cnt = 0;
  int bit_cnt = 0;
  logic [7:0] cur;
  initial flash_data_o = 1'b0;
  initial header_o = 32'h0;
  // New selection starts a fresh header
  always @(negedge flash_select_low_i) begin
    header_o = 32'h0;
  end
  // Instruction then address come in on rising edges while selected
  always @(posedge config_clock_i) begin
    if (flash_select_low_i === 1'b0 && rise_cnt < 32) begin
      header_o = {header_o[30:0], serial_instr_in_i};
      rise_cnt++;
    end
  end
  // Data bits change on falling edges once the header is in
  always @(negedge config_clock_i) begin
    if (flash_select_low_i === 1'b0 && rise_cnt == 32) begin
      if (slow_i) #60;
      // A deselect during the delay cancels the bit
      if (flash_select_low_i === 1'b0) begin
        cur = 8'(bit_cnt / 8 * 29) ^ 8'ha5;
        flash_data_o = cur[7 - bit_cnt % 8];
        bit_cnt++;
      end
    end
  end
  // Deselected: forget the transfer, stop showing the last bit
  always @(posedge flash_select_low_i) begin
    rise_cnt = 0;
    bit_cnt = 0;
    flash_data_o = ~flash_data_o;
  end
endmodule // ascl_flash_model
`default_nettype wire

// ===== testbench/testbench.sv
/*
  Self-checking bench for the configuration master.
  Assumes the flash model and pull-ups on the done and error pins.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ascl_pkg::*;
  localparam int NBYTES = 40;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic start = 1'b0;
  logic [1:0] scheme = 2'h0;
  logic ready = 1'b0;
  logic hold_done = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic cclk, sel, sdo, data, done_o, done_oe, stat_o, stat_oe, valid, user, err;
  logic [7:0] bdata;
  logic [31:0] hdr;
  logic done_pin, stat_pin;
  int failures = 0;
  int samples_checked = 0;
  // Pull-ups on done and error; hold_done plays a chain member holding done low
  assign done_pin = !((done_oe && !done_o) || hold_done);
  assign stat_pin = !(stat_oe && !stat_o);
  ascl_master #(.IMAGE_BYTES(NBYTES)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
    .start_i(start), .scheme_select_i(scheme), .config_clock_o(cclk), .master_select_out_o(sel),
    .serial_instr_out_o(sdo), .config_data_in_i(data), .conf_done_i(done_pin), .conf_done_o(done_o),
    .conf_done_oe_o(done_oe), .status_low_i(stat_pin), .status_low_o(stat_o), .status_low_oe_o(stat_oe),
    .byte_data_o(bdata), .byte_valid_o(valid), .byte_ready_i(ready), .user_mode_o(user), .error_o(err));
  ascl_flash_model flash (.config_clock_i(cclk), .flash_select_low_i(sel), .serial_instr_in_i(sdo),
    .slow_i(slow), .flash_data_o(data), .header_o(hdr));
  // System clock, 100 ns period
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bound(input bit ok);
    if (!ok) begin
      failures++;
      $display("BAD t=%0t wait ran out", $time);
      summarize();
    end
  endtask
  function automatic logic [7:0] pat(input int n);
    return 8'(n * 29) ^ 8'ha5;
  endfunction
  task automatic do_reset();
    rst_i = 1'b1;
    repeat (3) tick();
    rst_i = 1'b0;
  endtask
  // Reset levels, then a start on a passive strap that must be ignored
  task automatic t_idle();
    check(sel, 1'b1);
    check(cclk, 1'b0);
    check({done_oe, stat_oe, valid, user, err}, 5'h0);
    scheme = SCHEME_PASSIVE;
    start = 1'b1;
    repeat (20) tick();
    check({sel, cclk, done_oe}, 3'h4);
    start = 1'b0;
    scheme = SCHEME_ACTIVE;
    tick();
    $display("test idle done");
  endtask
  // One configuration: optional reader stall, slow flash, done held low
  task automatic t_run(input bit stall, input bit slw, input bit late);
    int i;
    int n;
    logic [3:0] snap;
    i = 0;
    n = 0;
    slow = slw;
    hold_done = late;
    start = 1'b1;
    tick();
    start = 1'b0;
    tick();
    check({sel, cclk, done_oe, done_pin}, 4'h2);
    // Clock enable low must freeze the link pins for longer than a half period
    snap = {cclk, sel, sdo, done_oe};
    ce = 1'b0;
    repeat (12) tick();
    check({cclk, sel, sdo, done_oe}, snap);
    ce = 1'b1;
    if (stall) begin
      repeat (3000) tick();
      check({cclk, valid, sel}, 3'h2);
    end
    ready = 1'b1;
    while (i < NBYTES && n < 6000) begin
      if (valid === 1'b1) begin
        check(bdata, pat(i));
        i++;
      end
      tick();
      n++;
    end
    bound(i == NBYTES);
    check(hdr, {READ_OPCODE, 24'h000000});
    n = 0;
    while (sel !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    bound(n < 100);
    check({user, done_oe}, 2'h0);
    if (late) begin
      n = 0;
      while (stat_oe !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      bound(n < 20);
      n = 0;
      while (stat_pin === 1'b0 && n < 20) begin
        tick();
        n++;
      end
      bound(n < 20);
      check(n, INIT_CYC - 1);
      check({err, user}, 2'h2);
      hold_done = 1'b0;
    end else begin
      n = 0;
      while (user !== 1'b1 && n < 40) begin
        tick();
        n++;
      end
      bound(n < 40);
      check({user, err, done_oe, done_pin, stat_oe}, 5'h12);
    end
    ready = 1'b0;
    $display("test run done stall %0d slow %0d late %0d", stall, slw, late);
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_idle();
    t_run(1'b1, 1'b0, 1'b0);
    do_reset();
    t_run(1'b0, 1'b1, 1'b1);
    t_run(1'b0, 1'b0, 1'b0);
    summarize();
  end
endmodule // testbench
`default_nettype wire
